// >>> pkg/svt_defines.vh
// constants for the supervision timer: register offsets, field positions, reset values
// assumes an apb slave with 32-bit words at byte addresses
//
// What this block does
// - the counter advances on every rising system clock edge while enabled, no other clock source
// - sixteen time-out lengths, two to the power sixteen through thirty-one cycles
// - first time-out raises the fast interrupt and sets the time-out status flag
// - flag still set at the next time-out asserts a full system reset
// - software enable, lockout and keyed restart guard against stray writes
`ifndef SVT_DEFINES_VH
`define SVT_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SVT_OFS_CTRL 12'h000
`define SVT_OFS_RESTART 12'h004
`define SVT_OFS_STATUS 12'h008
`define SVT_OFS_INT_EN 12'h00c
`define SVT_OFS_INT_CLR 12'h010
`define SVT_OFS_COUNT 12'h014

// ----------------------------------------
// field positions
// ----------------------------------------
`define SVT_CTRL_EN 0
`define SVT_CTRL_LOCK 1
`define SVT_CTRL_SEL_LO 4
`define SVT_CTRL_SEL_HI 7
`define SVT_ST_FLAG 0
`define SVT_ST_RST 1

// ----------------------------------------
// values
// ----------------------------------------
`define SVT_RESTART_KEY 32'h0000_5a5a
`define SVT_SEL_RESET 4'h0
`define SVT_MIN_POW 16
`define SVT_RST_PULSE_NS 160
`define SVT_CLK_NS 10
`define SVT_RST_CYCLES (`SVT_RST_PULSE_NS / `SVT_CLK_NS)

`endif

// >>> rtl/svt_counter.v
// free running time-out counter with restart and tap select
// assumes one clock; restart and select are synchronous
`timescale 1ns/1ns
`include "svt_defines.vh"
module svt_counter #(
  parameter CNT_W = 32,
  parameter MIN_POW = `SVT_MIN_POW
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire run,
  input wire restart,
  input wire [3:0] sel,
  // status
  output wire timeout,
  output reg [CNT_W-1:0] count_r
);

  localparam [5:0] MIN_POW_W = MIN_POW;
  wire [CNT_W-1:0] count_nxt;
  wire [CNT_W-1:0] one;
  wire [CNT_W-1:0] mask;
  // tap bit index min_pow + sel, the counter wraps to zero one count before reaching it
  wire [5:0] tap_idx;

  assign tap_idx = MIN_POW_W + {2'b00, sel};
  assign one = {{(CNT_W-1){1'b0}}, 1'b1};
  // a mask instead of a variable part-select keeps the compare static
  assign mask = (one << tap_idx) - one;
  assign count_nxt = count_r + one;
  // time-out when the next count would reach two to the selected power
  assign timeout = run && ((count_r & mask) == mask);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= {CNT_W{1'b0}};
    end else if (restart || !run) begin
      count_r <= {CNT_W{1'b0}};
    end else if (timeout) begin
      count_r <= {CNT_W{1'b0}};
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule // svt_counter

// >>> rtl/svt_top.v
// supervision timer: apb registers, two-stage time-out, interrupt and system reset
// assumes apb master on pclk; sys_reset_req is caught by the chip reset logic
`timescale 1ns/1ns
`include "svt_defines.vh"
module svt_top #(
  parameter RST_CYCLES = `SVT_RST_CYCLES,
  parameter MIN_POW = `SVT_MIN_POW
) (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // events
  output wire fast_interrupt_request,
  output reg sys_reset_req_r
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  localparam [7:0] RST_CNT_INIT = RST_CYCLES;
  reg en_r;
  reg lock_r;
  reg [3:0] sel_r;
  reg [1:0] status_r;
  reg [1:0] int_en_r;
  reg [7:0] rst_cnt_r;
  wire [31:0] count;
  wire timeout;
  wire wr;
  wire rd;
  wire restart;
  wire hit;

  // one-cycle answer; unmapped addresses give pslverr
  function svt_dec;
    input [11:0] a;
    begin
      svt_dec = (a == `SVT_OFS_CTRL) || (a == `SVT_OFS_RESTART) || (a == `SVT_OFS_STATUS) ||
                (a == `SVT_OFS_INT_EN) || (a == `SVT_OFS_INT_CLR) || (a == `SVT_OFS_COUNT);
    end
  endfunction

  assign hit = svt_dec(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign wr = psel && penable && pwrite && hit;
  assign rd = psel && !pwrite;
  // only the exact key restarts the counter, stray values do nothing
  assign restart = wr && (paddr == `SVT_OFS_RESTART) && (pwdata == `SVT_RESTART_KEY);

  svt_counter #(
    .CNT_W(32),
    .MIN_POW(MIN_POW)
  ) u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .run(en_r),
    .restart(restart),
    .sel(sel_r),
    .timeout(timeout),
    .count_r(count)
  );

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 1'b0;
      lock_r <= 1'b0;
      sel_r <= `SVT_SEL_RESET;
      int_en_r <= 2'h0;
    end else if (wr) begin
      if (paddr == `SVT_OFS_CTRL) begin
        if (!lock_r) begin
          en_r <= pwdata[`SVT_CTRL_EN];
          sel_r <= pwdata[`SVT_CTRL_SEL_HI:`SVT_CTRL_SEL_LO];
          lock_r <= pwdata[`SVT_CTRL_LOCK];
        end else begin
          // locked: only enabling is still allowed, lock stays till reset
          en_r <= en_r | pwdata[`SVT_CTRL_EN];
        end
      end
      if (paddr == `SVT_OFS_INT_EN) begin
        int_en_r <= pwdata[1:0];
      end
    end
  end

  // ----------------------------------------
  // status, two-stage escalation
  // ----------------------------------------
  // set wins over a clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= 2'h0;
    end else begin
      status_r[`SVT_ST_FLAG] <= (status_r[`SVT_ST_FLAG] &
        ~(wr && paddr == `SVT_OFS_INT_CLR && pwdata[`SVT_ST_FLAG])) | timeout;
      status_r[`SVT_ST_RST] <= (status_r[`SVT_ST_RST] &
        ~(wr && paddr == `SVT_OFS_INT_CLR && pwdata[`SVT_ST_RST])) |
        (timeout & status_r[`SVT_ST_FLAG]);
    end
  end

  // reset pulse stretched so the chip reset logic sees it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset_req_r <= 1'b0;
      rst_cnt_r <= 8'h00;
    end else if (timeout && status_r[`SVT_ST_FLAG]) begin
      sys_reset_req_r <= 1'b1;
      rst_cnt_r <= RST_CNT_INIT;
    end else if (rst_cnt_r != 8'h00) begin
      rst_cnt_r <= rst_cnt_r - 8'h01;
      sys_reset_req_r <= (rst_cnt_r != 8'h01);
    end else begin
      sys_reset_req_r <= 1'b0;
    end
  end

  // fast interrupt level while any enabled status bit stands
  assign fast_interrupt_request = |(status_r & int_en_r);

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd && !penable) begin
      case (paddr)
        `SVT_OFS_CTRL: prdata <= {24'h000000, sel_r, 2'b00, lock_r, en_r};
        `SVT_OFS_STATUS: prdata <= {30'h00000000, status_r};
        `SVT_OFS_INT_EN: prdata <= {30'h00000000, int_en_r};
        `SVT_OFS_COUNT: prdata <= count;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // svt_top

// >>> verif/svt_props.sv
// port checker for svt_top
// assumes one clock pclk and presetn async low
`timescale 1ns/1ns
module svt_props #(parameter RST_CYCLES = 16) (
  // apb
  input wire pclk, input wire presetn, input wire psel, input wire penable, input wire pwrite,
  input wire [11:0] paddr, input wire [31:0] pwdata, input wire [31:0] prdata,
  input wire pready, input wire pslverr,
  // events
  input wire fast_interrupt_request, input wire sys_reset_req_r
);
  // ----
  // properties
  // ----
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence acc; psel && penable; endsequence
  sequence wr(a); acc ##0 pwrite && paddr == a; endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc ##0 paddr > 12'h014 |-> pslverr) else $error("no slverr");
  a_err_mapped: assert property (acc ##0 paddr < 12'h018 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("bad slverr");
  a_err_data: assert property (acc ##0 !pwrite && pslverr |-> prdata == 32'h0) else $error("err data");
  a_irq_off: assert property (wr(12'h00c) ##0 pwdata == 32'h0 |=> !fast_interrupt_request)
    else $error("irq on");
  a_irq_clear: assert property (wr(12'h010) ##0 pwdata[1:0] == 2'h3 |=> !fast_interrupt_request)
    else $error("irq kept");
  a_rst_hold: assert property ($rose(sys_reset_req_r) |=> sys_reset_req_r [*8])
    else $error("short reset");
  a_rst_end: assert property ($rose(sys_reset_req_r) |-> ##RST_CYCLES !sys_reset_req_r)
    else $error("long reset");
endmodule // svt_props
bind svt_top svt_props #(.RST_CYCLES(RST_CYCLES)) svt_props_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .fast_interrupt_request, .sys_reset_req_r);

// >>> verif/testbench.sv
// self-checking bench for svt_top over apb
// assumes the register layout of svt_defines.vh
`timescale 1ns/1ns
`include "svt_defines.vh"
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, sys_rst, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, c1;
  int failures = 0, checked = 0, cyc = 0, n, t1, h;
  // shortest period 2^10 so that two time-outs fit in the run
  localparam int MP = 10;
  always #5 pclk = ~pclk;
  svt_top #(.MIN_POW(MP)) svt_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .fast_interrupt_request(irq), .sys_reset_req_r(sys_rst));
  // ----
  // tasks
  // ----
  task wrap_up;
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task t_reset_vals;
    apb(0, `SVT_OFS_CTRL, 32'h0);
    cmp(rd, 32'h0);
    apb(0, `SVT_OFS_COUNT, 32'h0);
    cmp(rd, 32'h0);
    apb(1, 12'h020, 32'hffff_ffff);
    cmp(er, 32'h1);
    apb(0, 12'h020, 32'h0);
    cmp(er, 32'h1);
    cmp(rd, 32'h0);
  endtask
  task t_lock;
    apb(1, `SVT_OFS_CTRL, 32'h3);
    apb(1, `SVT_OFS_CTRL, 32'h10);
    apb(0, `SVT_OFS_CTRL, 32'h0);
    cmp(rd, 32'h3);
    apb(0, `SVT_OFS_COUNT, 32'h0);
    c1 = rd;
    apb(1, `SVT_OFS_RESTART, 32'h1234);
    apb(0, `SVT_OFS_COUNT, 32'h0);
    cmp(rd > c1, 32'h1);
    apb(1, `SVT_OFS_RESTART, `SVT_RESTART_KEY);
    apb(0, `SVT_OFS_COUNT, 32'h0);
    cmp(rd < 32'h8, 32'h1);
  endtask
  task t_timeout;
    apb(1, `SVT_OFS_INT_EN, 32'h1);
    apb(1, `SVT_OFS_RESTART, `SVT_RESTART_KEY);
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    t1 = cyc;
    cmp(n, 32'h1 << MP);
    apb(0, `SVT_OFS_STATUS, 32'h0);
    cmp(rd & 32'h3, 32'h1);
    apb(1, `SVT_OFS_INT_EN, 32'h0);
    #1 cmp(irq, 32'h0);
    apb(1, `SVT_OFS_INT_EN, 32'h1);
    #1 cmp(irq, 32'h1);
    // flag left set: the next time-out must ask for a system reset
    while (sys_rst !== 1'b1 && cyc - t1 < 5000) begin
      @(posedge pclk);
      #1;
    end
    cmp(cyc - t1, 32'h1 << MP);
    h = 0;
    while (sys_rst === 1'b1 && h < 100) begin
      @(posedge pclk);
      #1;
      h++;
    end
    cmp(h, `SVT_RST_CYCLES);
    apb(0, `SVT_OFS_STATUS, 32'h0);
    cmp(rd & 32'h3, 32'h3);
    apb(1, `SVT_OFS_INT_CLR, 32'h3);
    #1 cmp({irq, sys_rst}, 32'h0);
  endtask
  task t_sel;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1 cmp({irq, sys_rst}, 32'h0);
    apb(0, `SVT_OFS_CTRL, 32'h0);
    cmp(rd, 32'h0);
    apb(1, `SVT_OFS_INT_EN, 32'h1);
    apb(1, `SVT_OFS_CTRL, 32'h11);
    n = 0;
    while (irq !== 1'b1 && n < 9000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    cmp(n, 32'h2 << MP);
    apb(0, `SVT_OFS_CTRL, 32'h0);
    cmp(rd, 32'h11);
  endtask
  // ----
  // run
  // ----
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      failures++;
      wrap_up;
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_vals;
    t_lock;
    t_timeout;
    t_sel;
    wrap_up;
  end
endmodule // testbench
